// >>> rtl/scc_top.sv
`timescale 1ns/1ns
module scc_top #(
  parameter int N_OUT = 10,
  parameter int MCB_DATA_W = 8,
  parameter int N_MACRO = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Recovered clocks in and pads out.
  input wire logic [N_OUT-1:0] lane_clks,
  input wire logic bus_b_clk,
  output logic [N_OUT-1:0] recovered_clock_outputs,
  output logic [N_OUT-1:0] recovered_clock_outputs_oe,
  output logic bus_b_clk_out,
  // Macro configuration bus.
  output logic mcb_sdo,
  output logic mcb_frame,
  input wire logic mcb_sdi,
  // Clock-recovery loop.
  input wire logic pcs_sync,
  input wire logic dense_pattern,
  output scc_pkg::scc_loop_type loop_ctrl
);
  logic [N_OUT-1:0] recovered_clock_pad_enables_reg;
  logic [3:0] output0_source_select_reg;
  logic [N_OUT-1:0] common_source_select_reg;
  logic [1:0] bus_b_divider_select_reg;
  logic [N_MACRO-1:0] macro_select_vector_reg;
  logic [MCB_DATA_W-1:0] mcb_wdata_reg;
  logic [MCB_DATA_W-1:0] mcb_rdata_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [3:0] phase_regulator_mode_reg;
  logic [1:0] phase_detector_source_select_reg;
  logic [2:0] half_cycle_deadlock_mode_reg;
  logic [2:0] proportional_bandwidth_divider_reg;
  logic [2:0] integral_time_constant_reg;
  logic mcb_done;
  logic [MCB_DATA_W-1:0] mcb_rdata;
  logic mcb_sdo_int;
  logic mcb_frame_int;
  logic bus_b_div;

  // Address decode.
  wire wr_pad = reg_wr && (reg_addr == scc_pkg::OFS_PAD_EN);
  wire wr_src = reg_wr && (reg_addr == scc_pkg::OFS_SRC_SEL);
  wire wr_div = reg_wr && (reg_addr == scc_pkg::OFS_DIV);
  wire wr_mcb = reg_wr && (reg_addr == scc_pkg::OFS_MCB_CTRL);
  wire wr_mwd = reg_wr && (reg_addr == scc_pkg::OFS_MCB_WDATA);
  wire wr_des = reg_wr && (reg_addr == scc_pkg::OFS_DES_CFG);

  // Macro bus triggers; write wins when both bits are set together.
  wire mcb_busy = wr_pend_reg || rd_pend_reg;
  wire start_wr = wr_mcb && reg_wdata[scc_pkg::WR_TRIG_BIT] && !mcb_busy;
  wire start_rd = wr_mcb && reg_wdata[scc_pkg::RD_TRIG_BIT] &&
    !reg_wdata[scc_pkg::WR_TRIG_BIT] && !mcb_busy;

  // Recovered clock source selection.
  // source zero select
  wire src_ok = output0_source_select_reg < scc_pkg::NUM_SOURCES;
  wire common_src = src_ok ? lane_clks[output0_source_select_reg] : 1'b0;
  wire [N_OUT-1:0] indiv_src = {lane_clks[N_OUT-1:1], common_src};
  wire [N_OUT-1:0] pad_src = (indiv_src & ~common_source_select_reg) |
    ({N_OUT{common_src}} & common_source_select_reg);

  // Loop control decode.
  // top bit unused
  wire [2:0] phs_code = phase_regulator_mode_reg[2:0];
  scc_pkg::scc_loop_type loop_next;
  assign loop_next.reg_enable = (phs_code != 3'h0) && (!phs_code[2] || pcs_sync);
  assign loop_next.ppm_limit = phs_code[1:0];
  assign loop_next.pd_enable = phase_detector_source_select_reg != scc_pkg::CPMD_OFF;
  assign loop_next.pd_source = phase_detector_source_select_reg;
  assign loop_next.deadlock_block =
    (half_cycle_deadlock_mode_reg == scc_pkg::MBTR_DENSE) ? dense_pattern :
    (half_cycle_deadlock_mode_reg == scc_pkg::MBTR_UNSYNC) ? !pcs_sync :
    (half_cycle_deadlock_mode_reg == scc_pkg::MBTR_DENSE_UNSYNC) ?
      (dense_pattern && !pcs_sync) :
    (half_cycle_deadlock_mode_reg == scc_pkg::MBTR_ALWAYS);
  assign loop_next.prop_shift = proportional_bandwidth_divider_reg;
  assign loop_next.integ_shift = {1'b0, integral_time_constant_reg} + 4'h1;

  // Read multiplexer.
  wire [31:0] rd_pad = 32'(recovered_clock_pad_enables_reg);
  wire [31:0] rd_src = (32'(output0_source_select_reg) << scc_pkg::SEL0_LSB) |
    32'(common_source_select_reg);
  wire [31:0] rd_div = 32'(bus_b_divider_select_reg);
  wire [31:0] rd_mcb = (32'(wr_pend_reg) << scc_pkg::WR_TRIG_BIT) |
    (32'(rd_pend_reg) << scc_pkg::RD_TRIG_BIT) | 32'(macro_select_vector_reg);
  wire [31:0] rd_des =
    (32'(phase_regulator_mode_reg) << scc_pkg::PHS_LSB) |
    (32'(phase_detector_source_select_reg) << scc_pkg::CPMD_LSB) |
    (32'(half_cycle_deadlock_mode_reg) << scc_pkg::MBTR_LSB) |
    (32'(proportional_bandwidth_divider_reg) << scc_pkg::BWA_LSB) |
    (32'(integral_time_constant_reg) << scc_pkg::BWH_LSB);
  wire [31:0] rd_stat = {pcs_sync, 15'h0000, 16'(loop_ctrl)};
  wire [31:0] rd_mux =
    (reg_addr == scc_pkg::OFS_PAD_EN) ? rd_pad :
    (reg_addr == scc_pkg::OFS_SRC_SEL) ? rd_src :
    (reg_addr == scc_pkg::OFS_DIV) ? rd_div :
    (reg_addr == scc_pkg::OFS_MCB_CTRL) ? rd_mcb :
    (reg_addr == scc_pkg::OFS_MCB_WDATA) ? 32'(mcb_wdata_reg) :
    (reg_addr == scc_pkg::OFS_MCB_RDATA) ? 32'(mcb_rdata_reg) :
    (reg_addr == scc_pkg::OFS_DES_CFG) ? rd_des :
    (reg_addr == scc_pkg::OFS_DES_STAT) ? rd_stat : 32'h00000000;

  // Unmapped reads return zero and the data bus drops to zero after one cycle.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
  end

  // Recovered clock configuration.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      recovered_clock_pad_enables_reg <= '0;
      output0_source_select_reg <= 4'h0;
      common_source_select_reg <= '0;
      bus_b_divider_select_reg <= scc_pkg::DIV_NONE;
    end
    else
    begin
      if (wr_pad)
        recovered_clock_pad_enables_reg <= reg_wdata[N_OUT-1:0];
      if (wr_src)
      begin
        output0_source_select_reg <= reg_wdata[scc_pkg::SEL0_LSB +: 4];
        common_source_select_reg <= reg_wdata[N_OUT-1:0];
      end
      if (wr_div)
        bus_b_divider_select_reg <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      recovered_clock_outputs <= '0;
      recovered_clock_outputs_oe <= '0;
      bus_b_clk_out <= 1'b0;
    end
    else
    begin
      recovered_clock_outputs <= pad_src & recovered_clock_pad_enables_reg;
      recovered_clock_outputs_oe <= recovered_clock_pad_enables_reg;
      bus_b_clk_out <= bus_b_div;
    end
  end

  scc_div u_div (
    .clk(clk),
    .rstn(rstn),
    .mode(bus_b_divider_select_reg),
    .clk_in(bus_b_clk),
    .clk_out(bus_b_div)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      macro_select_vector_reg <= N_MACRO'(scc_pkg::RST_MACRO_SEL);
      mcb_wdata_reg <= '0;
    end
    else
    begin
      if (wr_mcb)
        macro_select_vector_reg <= reg_wdata[N_MACRO-1:0];
      if (wr_mwd)
        mcb_wdata_reg <= reg_wdata[MCB_DATA_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      mcb_rdata_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= start_wr || (wr_pend_reg && !mcb_done);
      rd_pend_reg <= start_rd || (rd_pend_reg && !mcb_done);
      if (mcb_done && rd_pend_reg)
        mcb_rdata_reg <= mcb_rdata;
    end
  end

  scc_mcb #(
    .DATA_W(MCB_DATA_W),
    .N_SLV(N_MACRO)
  ) u_mcb (
    .clk(clk),
    .rstn(rstn),
    .start(start_wr || start_rd),
    .is_wr(start_wr),
    .sel(macro_select_vector_reg),
    .wdata(mcb_wdata_reg),
    .done(mcb_done),
    .rdata(mcb_rdata),
    .sdo(mcb_sdo_int),
    .frame(mcb_frame_int),
    .sdi(mcb_sdi)
  );

  assign mcb_sdo = mcb_sdo_int;
  assign mcb_frame = mcb_frame_int;

  // Deserializer loop configuration.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_regulator_mode_reg <= scc_pkg::RST_PHS;
      phase_detector_source_select_reg <= scc_pkg::RST_CPMD;
      half_cycle_deadlock_mode_reg <= scc_pkg::RST_MBTR;
      proportional_bandwidth_divider_reg <= scc_pkg::RST_BWA;
      integral_time_constant_reg <= scc_pkg::RST_BWH;
    end
    else if (wr_des)
    begin
      phase_regulator_mode_reg <= reg_wdata[scc_pkg::PHS_LSB +: 4];
      phase_detector_source_select_reg <= reg_wdata[scc_pkg::CPMD_LSB +: 2];
      half_cycle_deadlock_mode_reg <= reg_wdata[scc_pkg::MBTR_LSB +: 3];
      proportional_bandwidth_divider_reg <= reg_wdata[scc_pkg::BWA_LSB +: 3];
      integral_time_constant_reg <= reg_wdata[scc_pkg::BWH_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      loop_ctrl <= '0;
    else
      loop_ctrl <= loop_next;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_pad_enable_write: assert property (
    wr_pad |=> ##1 (recovered_clock_outputs_oe == $past(reg_wdata[N_OUT-1:0], 2)))
    else $error("pad enables do not follow the written value");
  a_common_source_route: assert property (
    common_source_select_reg[1] && recovered_clock_pad_enables_reg[1] &&
    output0_source_select_reg == 4'h5 |=> recovered_clock_outputs[1] == $past(lane_clks[5]))
    else $error("common source not routed to output one");
  a_div_bypass: assert property (
    bus_b_divider_select_reg == scc_pkg::DIV_NONE && $past(bus_b_divider_select_reg) ==
    scc_pkg::DIV_NONE |=> bus_b_clk_out == $past(bus_b_clk, 2))
    else $error("bus B clock not passed through undivided");
  a_write_pending: assert property (
    start_wr || (wr_pend_reg && !mcb_done) |=> wr_pend_reg)
    else $error("write trigger not held pending");
  a_read_pending_clear: assert property (
    rd_pend_reg && mcb_done |=> !rd_pend_reg)
    else $error("read trigger not cleared on completion");
  a_write_readback: assert property (
    reg_rd && reg_addr == scc_pkg::OFS_MCB_CTRL && wr_pend_reg |=> reg_rdata[31])
    else $error("write trigger reads zero while pending");
  a_select_vector: assert property (
    wr_mcb |=> macro_select_vector_reg == $past(reg_wdata[N_MACRO-1:0]))
    else $error("macro select vector not stored");
  a_busy_no_restart: assert property (
    wr_mcb && reg_wdata[31] && rd_pend_reg && !mcb_done |=> !wr_pend_reg)
    else $error("second transfer started while busy");
  a_zero_trigger: assert property (
    wr_mcb && reg_wdata[31:30] == 2'h0 && !mcb_busy |=> !wr_pend_reg && !rd_pend_reg)
    else $error("zero trigger started a transfer");
  a_regulator_gate: assert property (
    phs_code == 3'h0 || (phs_code[2] && !pcs_sync) |=> !loop_ctrl.reg_enable)
    else $error("phase regulator enabled when it must be off");
  a_detector_off: assert property (
    phase_detector_source_select_reg == 2'h3 |=> !loop_ctrl.pd_enable)
    else $error("phase detector not disabled by code three");
  a_deadlock_never: assert property (
    half_cycle_deadlock_mode_reg == 3'h3 |=> !loop_ctrl.deadlock_block)
    else $error("deadlock block active in never mode");
  a_integ_shift: assert property (
    wr_des |=> ##1 (loop_ctrl.integ_shift == 4'($past(reg_wdata[3:1], 2)) + 4'h1))
    else $error("integral shift is not code plus one");

  c_write_done: cover property (start_wr ##[1:40] mcb_done);
  c_read_done: cover property (start_rd ##[1:40] mcb_done);
  c_sync_regulator: cover property (phs_code[2] && pcs_sync ##1 loop_ctrl.reg_enable);
  c_div_five: cover property (bus_b_divider_select_reg == scc_pkg::DIV_BY5 && bus_b_clk_out);
endmodule : scc_top

// >>> rtl/scc_pkg.sv
// Summary of operation
// - Ten pad enables, zero means high-impedance.
// - Four-bit source select for output zero.
// - Outputs one to nine choose individual or common source; output zero always takes the common source.
// - Bus B divider: none, five, four.
// - One chained serial slave per analog macro.
// - Write trigger reads one until done.
// - Read trigger reads one until done.
// - One-hot macro select, resets to macro zero.
// - Phase regulator modes, some gated by sync.
// - Phase detector source select, code three disables.
// - Half-cycle deadlock block mode, reset two.
// - Proportional path divided by two^code.
// - Integral path divided by two^(code+1).
package scc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_PAD_EN = 8'h00;
  localparam logic [7:0] OFS_SRC_SEL = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_MCB_CTRL = 8'h10;
  localparam logic [7:0] OFS_MCB_WDATA = 8'h14;
  localparam logic [7:0] OFS_MCB_RDATA = 8'h18;
  localparam logic [7:0] OFS_DES_CFG = 8'h20;
  localparam logic [7:0] OFS_DES_STAT = 8'h24;
  // Field positions.
  localparam int SEL0_LSB = 16;
  localparam int WR_TRIG_BIT = 31;
  localparam int RD_TRIG_BIT = 30;
  localparam int PHS_LSB = 13;
  localparam int CPMD_LSB = 11;
  localparam int MBTR_LSB = 8;
  localparam int BWA_LSB = 5;
  localparam int BWH_LSB = 1;
  // Values after reset.
  localparam logic [3:0] RST_PHS = 4'h6;
  localparam logic [1:0] RST_CPMD = 2'h0;
  localparam logic [2:0] RST_MBTR = 3'h2;
  localparam logic [2:0] RST_BWA = 3'h6;
  localparam logic [2:0] RST_BWH = 3'h7;
  localparam logic [1:0] RST_MACRO_SEL = 2'h1;
  // Encodings.
  localparam logic [3:0] NUM_SOURCES = 4'hA;
  localparam logic [1:0] DIV_NONE = 2'h0;
  localparam logic [1:0] DIV_BY5 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] CPMD_OFF = 2'h3;
  localparam logic [2:0] MBTR_DENSE = 3'h0;
  localparam logic [2:0] MBTR_UNSYNC = 3'h1;
  localparam logic [2:0] MBTR_DENSE_UNSYNC = 3'h2;
  localparam logic [2:0] MBTR_ALWAYS = 3'h4;
  // Full output periods of the bus B divider, counted in input edges.
  localparam int DIV5_EDGES = 10;
  localparam int DIV4_EDGES = 8;

  typedef enum {MCB_IDLE, MCB_SHIFT, MCB_DONE} scc_mcb_state_type;

  // Decoded clock-recovery loop controls; ppm_limit 0..3 = 50, 99, 202, 485 ppm.
  typedef struct packed {
    logic reg_enable;
    logic [1:0] ppm_limit;
    logic pd_enable;
    logic [1:0] pd_source;
    logic deadlock_block;
    logic [2:0] prop_shift;
    logic [3:0] integ_shift;
  } scc_loop_type;
endpackage : scc_pkg

// >>> rtl/scc_div.sv
`timescale 1ns/1ns
module scc_div (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Divider control and clocks.
  input wire logic [1:0] mode,
  input wire logic clk_in,
  output logic clk_out
);
  logic prev_reg;
  logic [3:0] cnt_reg;
  wire edge_seen = clk_in ^ prev_reg;
  wire [3:0] span = (mode == scc_pkg::DIV_BY5) ? 4'(scc_pkg::DIV5_EDGES) :
    4'(scc_pkg::DIV4_EDGES);
  wire [3:0] cnt_next = (cnt_reg >= span - 4'h1) ? 4'h0 : cnt_reg + 4'h1;

  // Counting both edges keeps the divide-by-five output at half duty.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_reg <= 1'b0;
      cnt_reg <= 4'h0;
      clk_out <= 1'b0;
    end
    else
    begin
      prev_reg <= clk_in;
      if (edge_seen)
        cnt_reg <= cnt_next;
      if (mode == scc_pkg::DIV_NONE)
        clk_out <= clk_in;
      else if (mode == 2'h3)
        clk_out <= 1'b0;
      else
        clk_out <= (cnt_reg < (span >> 1));
    end
  end
endmodule : scc_div

// >>> rtl/scc_mcb.sv
`timescale 1ns/1ns
module scc_mcb #(
  parameter int DATA_W = 8,
  parameter int N_SLV = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Transfer request.
  input wire logic start,
  input wire logic is_wr,
  input wire logic [N_SLV-1:0] sel,
  input wire logic [DATA_W-1:0] wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // Serial loop.
  output logic sdo,
  output logic frame,
  input wire logic sdi
);
  localparam int SLOT = DATA_W + 2;
  localparam int LEN = N_SLV * SLOT;
  localparam int CW = $clog2(LEN + 1);
  scc_pkg::scc_mcb_state_type state_reg;
  logic [LEN-1:0] sh_reg;
  logic [LEN-1:0] load_word;
  logic [CW-1:0] cnt_reg;

  always_comb
  begin
    load_word = '0;
    for (int i = 0; i < N_SLV; i++)
      load_word[(N_SLV-1-i)*SLOT +: SLOT] = {sel[i], is_wr, wdata};
  end

  assign rdata = sh_reg[LEN-3 -: DATA_W];

  // The frame leaves MSB first and comes back round the loop into the LSB.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= scc_pkg::MCB_IDLE;
      sh_reg <= '0;
      cnt_reg <= '0;
      sdo <= 1'b0;
      frame <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        scc_pkg::MCB_IDLE:
        begin
          if (start)
          begin
            sh_reg <= load_word;
            cnt_reg <= CW'(LEN);
            state_reg <= scc_pkg::MCB_SHIFT;
          end
        end
        scc_pkg::MCB_SHIFT:
        begin
          frame <= 1'b1;
          sdo <= sh_reg[LEN-1];
          sh_reg <= {sh_reg[LEN-2:0], sdi};
          cnt_reg <= cnt_reg - CW'(1);
          if (cnt_reg == CW'(1))
            state_reg <= scc_pkg::MCB_DONE;
        end
        scc_pkg::MCB_DONE:
        begin
          frame <= 1'b0;
          sdo <= 1'b0;
          done <= 1'b1;
          state_reg <= scc_pkg::MCB_IDLE;
        end
        default: state_reg <= scc_pkg::MCB_IDLE;
      endcase
    end
  end
endmodule : scc_mcb

// >>> tb/scc_top_test.sv
`timescale 1ns/1ns
module scc_top_test;
  typedef struct packed
  {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } scc_row_type;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [9:0] lane_clks = 10'h2A5;
  logic bus_b_clk = 1'b0;
  logic [9:0] pads;
  logic [9:0] pads_oe;
  logic bus_b_clk_out;
  logic mcb_sdo;
  logic mcb_frame;
  logic mcb_sdi = 1'b0;
  logic pcs_sync = 1'b0;
  logic dense_pattern = 1'b0;
  scc_pkg::scc_loop_type loop_ctrl;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_frame = 0;
  scc_row_type rows [8];

  scc_top i_scc_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_clks(lane_clks),
    .bus_b_clk(bus_b_clk), .recovered_clock_outputs(pads), .recovered_clock_outputs_oe(pads_oe),
    .bus_b_clk_out(bus_b_clk_out), .mcb_sdo(mcb_sdo), .mcb_frame(mcb_frame), .mcb_sdi(mcb_sdi),
    .pcs_sync(pcs_sync), .dense_pattern(dense_pattern), .loop_ctrl(loop_ctrl));

  always #2 clk = ~clk;

  // The serial loop is closed back on itself, as the chained slaves would be.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    bus_b_clk <= cyc[1];
    mcb_sdi <= mcb_sdo;
    if (mcb_frame === 1'b1)
      n_frame <= n_frame + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rd_chk

  function automatic logic [9:0] pad_exp(input logic [9:0] ln, input logic [9:0] en,
    input logic [9:0] cs, input logic [3:0] s0);
    logic c;
    logic [9:0] r;
    c = (s0 < 4'hA) ? ln[s0] : 1'b0;
    for (int i = 0; i < 10; i++)
      r[i] = ((cs[i] || i == 0) ? c : ln[i]) & en[i];
    return r;
  endfunction : pad_exp

  function automatic logic dl_exp(input logic [2:0] m, input logic s, input logic d);
    case (m)
      3'h0: return d;
      3'h1: return !s;
      3'h2: return d && !s;
      3'h4: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : dl_exp

  // Waits for a trigger bit to fall, at most 41 polls.
  task automatic wait_idle(input int bit_no);
    logic [31:0] d;
    int k;
    k = 0;
    rd(scc_pkg::OFS_MCB_CTRL, d);
    while (d[bit_no] !== 1'b0 && k < 40)
    begin
      rd(scc_pkg::OFS_MCB_CTRL, d);
      k++;
    end
    chk("trigger cleared", 32'h0, {31'h0, d[bit_no]});
  endtask : wait_idle

  task automatic count_rises(input int n, output int r);
    logic p;
    r = 0;
    p = bus_b_clk_out;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (bus_b_clk_out === 1'b1 && p === 1'b0)
        r++;
      p = bus_b_clk_out;
    end
  endtask : count_rises

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    logic [3:0] ph;
    logic [31:0] d;
    int r;
    rows[0] = '{8'h00, 32'hFFFFFFFF, 32'h000003FF};
    rows[1] = '{8'h04, 32'hFFFFFFFF, 32'h000F03FF};
    rows[2] = '{8'h08, 32'hFFFFFFFF, 32'h00000003};
    rows[3] = '{8'h20, 32'hFFFEFFFF, 32'h0000FFEE};
    rows[4] = '{8'h10, 32'h00000002, 32'h00000002};
    rows[5] = '{8'h14, 32'hFFFFFFFF, 32'h000000FF};
    rows[6] = '{8'h18, 32'hFFFFFFFF, 32'h00000000};
    rows[7] = '{8'h30, 32'hFFFFFFFF, 32'h00000000};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk("register readback", rows[i].addr, rows[i].rexp);
    end
    chk("frames after zero trigger", 32'h0, n_frame);
    for (int k = 0; k < 3; k++)
    begin
      logic [9:0] en;
      logic [9:0] cs;
      logic [3:0] s0;
      en = (k == 1) ? 10'h155 : 10'h3FF;
      cs = (k == 0) ? 10'h000 : ((k == 1) ? 10'h0F0 : 10'h3FF);
      s0 = (k == 0) ? 4'h3 : ((k == 1) ? 4'h5 : 4'hC);
      wr(scc_pkg::OFS_PAD_EN, {22'h0, en});
      wr(scc_pkg::OFS_SRC_SEL, {12'h0, s0, 6'h0, cs});
      repeat (4) @(posedge clk);
      #1;
      chk("pad enable", {22'h0, en}, {22'h0, pads_oe});
      chk("pad data", pad_exp(lane_clks, en, cs, s0), {22'h0, pads});
    end
    // loop decode across sync and density.
    for (int k = 0; k < 16; k++)
    begin
      ph = {1'b0, k[2:0]};
      @(posedge clk);
      pcs_sync <= k[3];
      dense_pattern <= k[0] ^ k[3];
      wr(scc_pkg::OFS_DES_CFG, {15'h0, ph, k[1:0], k[2:0], k[2:0], 1'b0, ~k[2:0], 1'b0});
      repeat (3) @(posedge clk);
      #1;
      chk("regulator enable", {31'h0, ph != 0 && (ph < 4 || k[3])},
        {31'h0, loop_ctrl.reg_enable});
      if (ph != 0)
        chk("ppm limit", (ph < 4) ? ph : ph - 4'h4, loop_ctrl.ppm_limit);
      chk("detector enable", {31'h0, k[1:0] != 2'h3}, {31'h0, loop_ctrl.pd_enable});
      if (k[1:0] != 2'h3)
        chk("detector source", k[1:0], loop_ctrl.pd_source);
      chk("deadlock block", dl_exp(k[2:0], k[3], k[0] ^ k[3]), loop_ctrl.deadlock_block);
      chk("prop shift", k[2:0], loop_ctrl.prop_shift);
      chk("integ shift", {1'b0, ~k[2:0]} + 4'h1, loop_ctrl.integ_shift);
    end
    // write transfer with a refused trigger while pending.
    wr(scc_pkg::OFS_MCB_CTRL, 32'h80000001);
    rd_chk("write pending", scc_pkg::OFS_MCB_CTRL, 32'h80000001);
    wr(scc_pkg::OFS_MCB_CTRL, 32'h40000001);
    wait_idle(31);
    rd(scc_pkg::OFS_MCB_CTRL, d);
    chk("no read after busy", 32'h0, {30'h0, d[31:30]});
    chk("one write frame", 32'd20, n_frame);
    wr(scc_pkg::OFS_MCB_CTRL, 32'h40000001);
    rd_chk("read pending", scc_pkg::OFS_MCB_CTRL, 32'h40000001);
    wait_idle(30);
    chk("read frame", 32'd40, n_frame);
    for (int m = 0; m < 4; m++)
    begin
      wr(scc_pkg::OFS_DIV, m);
      repeat (16) @(posedge clk);
      count_rises(160, r);
      d = (m == 0) ? 40 : ((m == 1) ? 8 : ((m == 2) ? 10 : 0));
      chk("divider in range", 32'h1, {31'h0, r + 1 >= d && r <= d + 1});
    end
    // Mid-run reset returns the pad enable, select, divider, macro select and loop config fields to their reset values.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("oe in reset", 32'h0, {22'h0, pads_oe});
    rstn <= 1'b1;
    rd_chk("pad enable reset", scc_pkg::OFS_PAD_EN, 32'h0);
    rd_chk("select reset", scc_pkg::OFS_SRC_SEL, 32'h0);
    rd_chk("divider reset", scc_pkg::OFS_DIV, 32'h0);
    rd_chk("macro select reset", scc_pkg::OFS_MCB_CTRL, 32'h1);
    rd_chk("loop config reset", scc_pkg::OFS_DES_CFG, 32'h0000C2CE);
    conclude();
  end
endmodule : scc_top_test
